// >>> ee_host_access.sv
`timescale 1ns/1ps

module ee_host_access
    import ee_pkg::*;
#(
    parameter int WR_WAIT  = WR_CYC,
    parameter int QTR_WAIT = QTR_CYC
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Configuration
    input  wire logic        reset_load_done,
    input  wire logic        eeprom_direct_access_enable,
    input  wire logic        eeprom_present,
    // Direct control/status register
    input  wire logic        cs_wr_en,
    input  wire logic [31:0] cs_wr_data,
    output logic      [31:0] cs_rd_data,
    // Product-data registers
    input  wire logic        vpd_data_wr_en,
    input  wire logic [31:0] vpd_data_wr_val,
    input  wire logic        vpd_addr_wr_en,
    input  wire logic [7:0]  vpd_addr_wr,
    input  wire logic        vpd_flag_wr,
    output logic      [7:0]  vpd_addr,
    output logic             vpd_flag,
    output logic      [31:0] vpd_data,
    output logic             vpd_cap_en,
    // Two-wire pins
    output logic             scl_out,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe
);

    typedef struct packed {
        ee_state_e   st;
        logic [6:0]  div;
        logic [1:0]  ph;
        logic [3:0]  bitn;
        logic [1:0]  idx;
        logic [7:0]  sh;
        logic [17:0] wcnt;
        logic        scl;
        logic        sda;
        logic [2:0]  sync;
        logic        sda_q;
        logic        job_vpd;
        logic        job_rd;
        logic [1:0]  k;
        logic [7:0]  ee_addr;
        logic [7:0]  cs_addr;
        logic [7:0]  cs_data;
        logic        cs_read;
        logic        act;
        logic [7:0]  vpd_addr;
        logic        vpd_flag;
        logic [31:0] vpd_data;
        logic        vbusy;
    } ee_regs_s;

    localparam logic [6:0]  QTR_LAST = 7'(QTR_WAIT - 1);
    localparam logic [17:0] WR_LAST  = 18'(WR_WAIT - 1);

    ee_regs_s r_ff;
    ee_regs_s nxt_r;
    logic     tick;
    logic     fin;
    logic     acc_en;
    logic     vpd_en;
    logic     cs_take;
    logic     vpd_take;

    // Byte placed on the wire for each slot of a transfer
    function automatic logic [7:0] byte_for(input ee_regs_s s, input logic [1:0] i);
        logic [7:0] w;
        w = s.job_vpd ? s.vpd_data[{s.k, 3'b000} +: 8] : s.cs_data;
        case (i)
            2'h0:      byte_for = DEV_WR;
            IDX_WADDR: byte_for = s.ee_addr;
            IDX_DATA:  byte_for = s.job_rd ? DEV_RD : w;
            default:   byte_for = RD_FILL;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Access enables

    assign acc_en = reset_load_done | eeprom_direct_access_enable;
    assign vpd_cap_en = eeprom_present;
    assign vpd_en = acc_en & eeprom_present;

    assign cs_take = cs_wr_en & acc_en & ~r_ff.act & ~r_ff.vbusy;
    assign vpd_take = vpd_addr_wr_en & vpd_en & ~r_ff.act & ~r_ff.vbusy
                    & (vpd_addr_wr <= VPD_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_r = r_ff;
        tick = 1'b0;
        fin = 1'b0;
        nxt_r.sync = {r_ff.sync[1:0], sda_in};
        if (r_ff.sync[2] == r_ff.sync[1]) begin
            nxt_r.sda_q = r_ff.sync[2];
        end

        // Bit-rate divider only runs while the wire is in use
        if (r_ff.st == EE_IDLE || r_ff.st == EE_TWR) begin
            nxt_r.div = '0;
        end else if (r_ff.div == QTR_LAST) begin
            nxt_r.div = '0;
            tick = 1'b1;
        end else begin
            nxt_r.div = r_ff.div + 7'h1;
        end

        if (cs_take) begin
            nxt_r.cs_addr = cs_wr_data[CS_ADDR_LSB +: 8];
            nxt_r.cs_data = cs_wr_data[CS_DATA_LSB +: 8];
            nxt_r.cs_read = cs_wr_data[CS_READ_BIT];
            nxt_r.act = 1'b1;
            nxt_r.job_vpd = 1'b0;
            nxt_r.job_rd = cs_wr_data[CS_READ_BIT];
            nxt_r.ee_addr = cs_wr_data[CS_ADDR_LSB +: 8];
            nxt_r.k = '0;
            nxt_r.idx = '0;
            nxt_r.ph = '0;
            nxt_r.st = EE_START;
        end

        if (vpd_data_wr_en && vpd_en && !r_ff.vbusy) begin
            nxt_r.vpd_data = vpd_data_wr_val;
        end

        if (vpd_addr_wr_en && vpd_en && !r_ff.act && !r_ff.vbusy) begin
            nxt_r.vpd_flag = vpd_flag_wr;
        end

        if (vpd_take) begin
            nxt_r.vpd_addr = vpd_addr_wr;
            nxt_r.vbusy = 1'b1;
            nxt_r.job_vpd = 1'b1;
            nxt_r.job_rd = ~vpd_flag_wr;
            nxt_r.ee_addr = vpd_addr_wr + VPD_BASE;
            nxt_r.k = '0;
            nxt_r.idx = '0;
            nxt_r.ph = '0;
            nxt_r.st = EE_START;
        end

        if (tick) begin
            nxt_r.ph = r_ff.ph + 2'h1;
        end
        case (r_ff.st)
            EE_START: begin
                if (tick) begin
                    case (r_ff.ph)
                        2'h0: begin
                            nxt_r.scl = 1'b0;
                            nxt_r.sda = 1'b1;
                        end
                        PH_HIGH:   nxt_r.scl = 1'b1;
                        PH_SAMPLE: nxt_r.sda = 1'b0;
                        default: begin
                            nxt_r.scl = 1'b0;
                            nxt_r.bitn = '0;
                            nxt_r.sh = byte_for(r_ff, r_ff.idx);
                            nxt_r.st = EE_BIT;
                        end
                    endcase
                end
            end
            EE_BIT: begin
                if (tick) begin
                    case (r_ff.ph)
                        2'h0: begin
                            nxt_r.scl = 1'b0;
                            // Ack slot is released; a read ends with no-ack
                            nxt_r.sda = (r_ff.bitn == ACK_BIT) ? 1'b1 : r_ff.sh[7];
                        end
                        PH_HIGH: nxt_r.scl = 1'b1;
                        PH_SAMPLE: begin
                            if (r_ff.bitn != ACK_BIT) begin
                                nxt_r.sh = {r_ff.sh[6:0], r_ff.sda_q};
                            end
                        end
                        default: begin
                            nxt_r.scl = 1'b0;
                            if (r_ff.bitn != ACK_BIT) begin
                                nxt_r.bitn = r_ff.bitn + 4'h1;
                            end else if (r_ff.idx == IDX_RDATA) begin
                                if (r_ff.job_vpd) begin
                                    nxt_r.vpd_data[{r_ff.k, 3'b000} +: 8] = r_ff.sh;
                                end else begin
                                    nxt_r.cs_data = r_ff.sh;
                                end
                                nxt_r.st = EE_STOP;
                            end else if (r_ff.idx == IDX_WADDR && r_ff.job_rd) begin
                                nxt_r.idx = IDX_DATA;
                                nxt_r.st = EE_START;
                            end else if (r_ff.idx == IDX_DATA && !r_ff.job_rd) begin
                                nxt_r.st = EE_STOP;
                            end else begin
                                nxt_r.idx = r_ff.idx + 2'h1;
                                nxt_r.bitn = '0;
                                nxt_r.sh = byte_for(r_ff, r_ff.idx + 2'h1);
                            end
                        end
                    endcase
                end
            end
            EE_STOP: begin
                if (tick) begin
                    case (r_ff.ph)
                        2'h0: begin
                            nxt_r.scl = 1'b0;
                            nxt_r.sda = 1'b0;
                        end
                        PH_HIGH:   nxt_r.scl = 1'b1;
                        PH_SAMPLE: nxt_r.sda = 1'b1;
                        default: begin
                            nxt_r.wcnt = '0;
                            if (r_ff.job_rd) begin
                                fin = 1'b1;
                            end else begin
                                nxt_r.st = EE_TWR;
                            end
                        end
                    endcase
                end
            end
            EE_TWR: begin
                // Fixed internal write time; no ack polling kept simple
                if (r_ff.wcnt == WR_LAST) begin
                    fin = 1'b1;
                end else begin
                    nxt_r.wcnt = r_ff.wcnt + 18'h1;
                end
            end
            EE_IDLE: begin
                nxt_r.scl = 1'b1;
                nxt_r.sda = 1'b1;
            end
            default: nxt_r.st = EE_IDLE;
        endcase

        // Byte finished: next lane or close the job
        if (fin) begin
            if (r_ff.job_vpd && r_ff.k != LAST_BYTE) begin
                nxt_r.k = r_ff.k + 2'h1;
                nxt_r.ee_addr = r_ff.ee_addr + 8'h1;
                nxt_r.idx = '0;
                nxt_r.ph = '0;
                nxt_r.st = EE_START;
            end else begin
                nxt_r.st = EE_IDLE;
                if (r_ff.job_vpd) begin
                    nxt_r.vbusy = 1'b0;
                    nxt_r.vpd_flag = r_ff.job_rd;
                end else begin
                    nxt_r.act = 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk) begin
        if (srst) begin
            r_ff <= '0;
            r_ff.st <= EE_IDLE;
            r_ff.scl <= 1'b1;
            r_ff.sda <= 1'b1;
            r_ff.sync <= 3'h7;
            r_ff.sda_q <= 1'b1;
        end else begin
            r_ff <= nxt_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        cs_rd_data = '0;
        cs_rd_data[CS_DATA_LSB +: 8] = r_ff.cs_data;
        cs_rd_data[CS_ADDR_LSB +: 8] = r_ff.cs_addr;
        cs_rd_data[CS_READ_BIT] = r_ff.cs_read;
        cs_rd_data[CS_ACT_BIT] = r_ff.act;
    end

    assign vpd_addr = r_ff.vpd_addr;
    assign vpd_flag = r_ff.vpd_flag;
    assign vpd_data = r_ff.vpd_data;
    assign scl_out = r_ff.scl;
    assign sda_out = 1'b0;
    assign sda_oe = ~r_ff.sda;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence stop_rise_s;
        r_ff.st == EE_STOP && r_ff.ph == PH_SAMPLE && tick;
    endsequence

    sequence vpd_done_s;
        r_ff.vbusy && !nxt_r.vbusy;
    endsequence

    busy_drop_a: assert property (cs_wr_en && r_ff.act |=> $stable(r_ff.cs_addr) && $stable(r_ff.cs_read))
        else $error("direct write changed register while busy");
    cs_start_a: assert property (cs_take |=> r_ff.act && r_ff.st == EE_START
                                 && r_ff.cs_addr == $past(cs_wr_data[CS_ADDR_LSB +: 8]))
        else $error("direct write did not start an access");
    no_enable_a: assert property (!acc_en && cs_wr_en && !r_ff.act |=> !r_ff.act)
        else $error("access started while disabled");
    range_skip_a: assert property (vpd_addr_wr_en && vpd_addr_wr > VPD_MAX |=> $stable(r_ff.vpd_addr) && !$rose(r_ff.vbusy))
        else $error("out of range address was taken");
    addr_offset_a: assert property (vpd_take |=> r_ff.ee_addr == 8'($past(vpd_addr_wr) + VPD_BASE))
        else $error("wrong EEPROM address formed");
    cap_off_a: assert property (!eeprom_present |-> !vpd_cap_en && !vpd_take)
        else $error("capability shown without EEPROM");
    rd_flag_a: assert property (vpd_done_s and r_ff.job_rd |=> r_ff.vpd_flag && r_ff.st == EE_IDLE)
        else $error("read flag not set at completion");
    wr_flag_a: assert property (vpd_done_s and !r_ff.job_rd |=> !r_ff.vpd_flag && r_ff.st == EE_IDLE)
        else $error("write flag not cleared at completion");
    act_end_a: assert property ($fell(r_ff.act) |-> r_ff.st == EE_IDLE && $past(r_ff.st) != EE_BIT)
        else $error("busy cleared before the stop");
    stop_wire_a: assert property (stop_rise_s |=> r_ff.scl && r_ff.sda ##1 !sda_oe)
        else $error("stop condition malformed");

endmodule

// >>> ee_host_access_tb.sv
`timescale 1ns/1ps
module ee_host_access_tb;
    import ee_pkg::*;

    localparam int WAIT_CYC = 20;
    localparam int QTR_TB   = 4;

    logic        clk;
    logic        srst;
    logic        reset_load_done;
    logic        eeprom_direct_access_enable;
    logic        eeprom_present;
    logic        cs_wr_en;
    logic [31:0] cs_wr_data;
    logic [31:0] cs_rd_data;
    logic        vpd_data_wr_en;
    logic [31:0] vpd_data_wr_val;
    logic        vpd_addr_wr_en;
    logic [7:0]  vpd_addr_wr;
    logic        vpd_flag_wr;
    logic [7:0]  vpd_addr;
    logic        vpd_flag;
    logic [31:0] vpd_data;
    logic        vpd_cap_en;
    logic        scl_out;
    logic        sda_in;
    logic        sda_out;
    logic        sda_oe;
    logic        rom_oe;
    int          fails;
    int          checks;

    // Data line has a pull-up: high unless someone pulls it low
    assign sda_in = ~(sda_oe | rom_oe);

    always #10 clk = ~clk;

    ee_host_access #(.WR_WAIT(WAIT_CYC), .QTR_WAIT(QTR_TB)) ee_host_access_inst (
        .clk(clk), .srst(srst), .reset_load_done(reset_load_done),
        .eeprom_direct_access_enable(eeprom_direct_access_enable),
        .eeprom_present(eeprom_present), .cs_wr_en(cs_wr_en),
        .cs_wr_data(cs_wr_data), .cs_rd_data(cs_rd_data),
        .vpd_data_wr_en(vpd_data_wr_en), .vpd_data_wr_val(vpd_data_wr_val),
        .vpd_addr_wr_en(vpd_addr_wr_en), .vpd_addr_wr(vpd_addr_wr),
        .vpd_flag_wr(vpd_flag_wr), .vpd_addr(vpd_addr), .vpd_flag(vpd_flag),
        .vpd_data(vpd_data), .vpd_cap_en(vpd_cap_en), .scl_out(scl_out),
        .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

    ee_serial_rom_model ee_serial_rom_model_inst (
        .scl(scl_out), .sda(sda_in), .sda_pull_oe(rom_oe));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cs_write(input logic [31:0] d);
        @(posedge clk);
        cs_wr_en <= 1'b1;
        cs_wr_data <= d;
        @(posedge clk);
        cs_wr_en <= 1'b0;
    endtask

    task automatic vpd_write_data(input logic [31:0] d);
        @(posedge clk);
        vpd_data_wr_en <= 1'b1;
        vpd_data_wr_val <= d;
        @(posedge clk);
        vpd_data_wr_en <= 1'b0;
    endtask

    task automatic vpd_write_addr(input logic [7:0] a, input logic f);
        @(posedge clk);
        vpd_addr_wr_en <= 1'b1;
        vpd_addr_wr <= a;
        vpd_flag_wr <= f;
        @(posedge clk);
        vpd_addr_wr_en <= 1'b0;
    endtask

    // Registers are looked at once the edge's updates have landed
    task automatic settle;
        @(posedge clk);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // All jobs together need about 6k cycles at the shortened bit rate
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test;
    end

    initial begin
        int poll;
        clk = 1'b0;
        srst = 1'b1;
        reset_load_done = 1'b0;
        eeprom_direct_access_enable = 1'b0;
        eeprom_present = 1'b1;
        cs_wr_en = 1'b0;
        cs_wr_data = 32'h0000_0000;
        vpd_data_wr_en = 1'b0;
        vpd_data_wr_val = 32'h0000_0000;
        vpd_addr_wr_en = 1'b0;
        vpd_addr_wr = 8'h00;
        vpd_flag_wr = 1'b0;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        cs_write(32'h4000_1000);
        settle;
        check(cs_rd_data, 32'h0000_0000);
        @(posedge clk);
        eeprom_direct_access_enable <= 1'b1;
        eeprom_present <= 1'b0;
        settle;
        check({31'h0, vpd_cap_en}, 32'h0000_0000);
        vpd_write_addr(8'h10, 1'b0);
        settle;
        check({23'h0, vpd_flag, vpd_addr}, 32'h0000_0000);
        @(posedge clk);
        eeprom_present <= 1'b1;
        settle;
        check({31'h0, vpd_cap_en}, 32'h0000_0001);
        vpd_write_addr(8'hE4, 1'b1);
        settle;
        check({23'h0, vpd_flag, vpd_addr}, 32'h0000_0100);
        vpd_write_data(32'h4433_2211);
        vpd_write_addr(8'hDC, 1'b1);
        settle;
        check({23'h0, vpd_flag, vpd_addr}, 32'h0000_01DC);
        cs_write(32'h4000_2000);
        settle;
        check(cs_rd_data, 32'h0000_0000);
        for (poll = 0; poll < 5000 && vpd_flag !== 1'b0; poll++) @(posedge clk);
        settle;
        check({23'h0, vpd_flag, vpd_addr}, 32'h0000_00DC);
        check({ee_serial_rom_model_inst.mem[8'hFF], ee_serial_rom_model_inst.mem[8'hFE],
               ee_serial_rom_model_inst.mem[8'hFD], ee_serial_rom_model_inst.mem[8'hFC]},
              32'h4433_2211);
        check({24'h0, ee_serial_rom_model_inst.mem[8'hFB]}, 32'h0000_0004);
        cs_write(32'h4000_FE00);
        settle;
        check({8'h0, cs_rd_data[31:8]}, 32'h00C0_00FE);
        cs_write(32'h0000_1055);
        settle;
        check({8'h0, cs_rd_data[31:8]}, 32'h00C0_00FE);
        for (poll = 0; poll < 5000 && cs_rd_data[31] !== 1'b0; poll++) @(posedge clk);
        settle;
        check(cs_rd_data, 32'h4000_FE33);
        // Direct byte write; a product-data start meanwhile is refused
        cs_write(32'h0000_FA5A);
        vpd_write_addr(8'h00, 1'b0);
        settle;
        check({23'h0, vpd_flag, vpd_addr}, 32'h0000_00DC);
        for (poll = 0; poll < 5000 && cs_rd_data[31] !== 1'b0; poll++) @(posedge clk);
        settle;
        check(cs_rd_data, 32'h0000_FA5A);
        check({24'h0, ee_serial_rom_model_inst.mem[8'hFA]}, 32'h0000_005A);
        // Product-data read of four lanes; a second start meanwhile is refused
        vpd_write_addr(8'hD8, 1'b0);
        vpd_write_addr(8'h10, 1'b1);
        settle;
        check({23'h0, vpd_flag, vpd_addr}, 32'h0000_00D8);
        for (poll = 0; poll < 5000 && vpd_flag !== 1'b1; poll++) @(posedge clk);
        settle;
        check({23'h0, vpd_flag, vpd_addr}, 32'h0000_01D8);
        check(vpd_data, 32'h045A_0607);
        finish_test;
    end
endmodule

// >>> ee_pkg.sv
package ee_pkg;

    // Clock and two-wire bus timing
    localparam int CLK_NS   = 20;
    localparam int T_QTR_NS = 2500;
    localparam int QTR_CYC  = (T_QTR_NS + CLK_NS - 1) / CLK_NS;
    localparam int T_WR_US  = 5000;
    localparam int WR_CYC   = (T_WR_US * 1000 + CLK_NS - 1) / CLK_NS;

    // Address window of the product-data path
    localparam logic [7:0] VPD_BASE = 8'h20;
    localparam logic [7:0] VPD_MAX  = 8'hE0;

    // Two-wire control bytes
    localparam logic [7:0] DEV_WR   = 8'hA0;
    localparam logic [7:0] DEV_RD   = 8'hA1;
    localparam logic [7:0] RD_FILL  = 8'hFF;

    // Direct register field positions
    localparam int CS_DATA_LSB = 0;
    localparam int CS_ADDR_LSB = 8;
    localparam int CS_READ_BIT = 30;
    localparam int CS_ACT_BIT  = 31;

    // Sequencer counts
    localparam logic [3:0] ACK_BIT   = 4'h8;
    localparam logic [1:0] PH_HIGH   = 2'h1;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_LAST   = 2'h3;
    localparam logic [1:0] IDX_WADDR = 2'h1;
    localparam logic [1:0] IDX_DATA  = 2'h2;
    localparam logic [1:0] IDX_RDATA = 2'h3;
    localparam logic [1:0] LAST_BYTE = 2'h3;

    typedef enum logic [2:0] {EE_IDLE, EE_START, EE_BIT, EE_STOP, EE_TWR} ee_state_e;

endpackage

// >>> ee_serial_rom_model.sv
`timescale 1ns/1ps
module ee_serial_rom_model (
    // Two-wire pins
    input  wire logic scl,
    input  wire logic sda,
    output logic      sda_pull_oe
);
    logic [7:0] mem [256];
    logic [7:0] sh;
    logic [7:0] ptr;
    logic [3:0] bitc;
    logic [1:0] byte_n;
    logic       rd;
    logic       rd_pend;

    // Each byte holds its inverted address, so stale data never looks fresh
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hFF;
        end
        sda_pull_oe = 1'b0;
        bitc = 4'h0;
        byte_n = 2'h0;
        rd = 1'b0;
        rd_pend = 1'b0;
        ptr = 8'h00;
        sh = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // Start and stop both restart the framing and drop any read
    always @(sda) begin
        if (scl === 1'b1) begin
            bitc = 4'h0;
            byte_n = 2'h0;
            rd = 1'b0;
            sda_pull_oe = 1'b0;
        end
    end

    always @(posedge scl) begin
        sh = {sh[6:0], sda};
        bitc = bitc + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // ack and data timing
    always @(negedge scl) begin
        if (bitc == 4'h8) begin
            sda_pull_oe = 1'b0;
            if (rd) begin
                ptr = ptr + 8'h1;
            end else begin
                sda_pull_oe = 1'b1;
                if (byte_n == 2'h0) begin
                    rd_pend = sh[0];
                end else if (byte_n == 2'h1) begin
                    ptr = sh;
                end else begin
                    mem[ptr] = sh;
                    ptr = ptr + 8'h1;
                end
                byte_n = byte_n + 2'h1;
            end
        end else if (bitc == 4'h9) begin
            bitc = 4'h0;
            sda_pull_oe = 1'b0;
            // A no-ack from the host ends the read so its stop can be seen
            if (rd && sh[0]) begin
                rd = 1'b0;
                rd_pend = 1'b0;
            end else if (rd_pend) begin
                rd = 1'b1;
            end
            if (rd) begin
                sda_pull_oe = ~mem[ptr][7];
            end
        end else if (rd && bitc != 4'h0) begin
            sda_pull_oe = ~mem[ptr][3'(4'h7 - bitc)];
        end
    end
endmodule
